// >>> inc/clpmc_pkg.sv
// Constants and types of the clock and low-power mode control
package clpmc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [4:0] IDX_INT_OSC = 5'h00;
	localparam logic [4:0] IDX_EXT_OSC = 5'h01;
	localparam logic [4:0] IDX_SRC_STAT = 5'h03;
	localparam logic [4:0] IDX_SRC_SW = 5'h04;
	localparam logic [4:0] IDX_SW_CTRL = 5'h05;
	localparam logic [4:0] IDX_CLK_DIV = 5'h06;
	localparam logic [4:0] IDX_GATE_ONE = 5'h07;
	localparam logic [4:0] IDX_CLK_SEC = 5'h08;
	localparam logic [4:0] IDX_CLK_OUT = 5'h09;
	localparam logic [4:0] IDX_GATE_TWO = 5'h0A;
	localparam logic [4:0] IDX_BUS_DIV = 5'h0B;
	localparam logic [4:0] IDX_RC_TRIM = 5'h0C;
	localparam logic [4:0] IDX_DBG_CLK = 5'h0D;
	localparam logic [4:0] IDX_MODE_STAT = 5'h10;
	// Reset values
	localparam logic [7:0] RST_INT_OSC = 8'h01;
	localparam logic [7:0] RST_SRC = 8'hE1;
	localparam logic [7:0] RST_CLK_DIV = 8'h18;
	localparam logic [7:0] RST_GATE = 8'hFF;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Master source code of the high-speed internal RC
	localparam logic [7:0] SRC_HSI = 8'hE1;
	// Writable bit masks
	localparam logic [7:0] WM_INT_OSC = 8'h2D;
	localparam logic [7:0] WM_EXT_OSC = 8'h01;
	localparam logic [7:0] WM_SW_CTRL = 8'h0E;
	localparam logic [7:0] WM_CLK_DIV = 8'h1F;
	localparam logic [7:0] WM_CLK_SEC = 8'h0D;
	localparam logic [7:0] WM_CLK_OUT = 8'h1F;
	localparam logic [7:0] WM_BUS_DIV = 8'h07;
	localparam logic [7:0] WM_RC_TRIM = 8'h07;
	localparam logic [7:0] WM_DBG_CLK = 8'h01;
	// Field positions
	localparam int B_REGULATOR_OFF_IN_ACTIVE_HALT = 5;
	localparam int B_LSIRDY = 4;
	localparam int B_LSIEN = 3;
	localparam int B_FHWU = 2;
	localparam int B_HSIRDY = 1;
	localparam int B_HSIEN = 0;
	localparam int B_HSERDY = 1;
	localparam int B_HSEEN = 0;
	localparam int B_SWEN = 1;
	localparam int B_CSSEN = 0;
	localparam int B_AWU_GATE = 2;
	localparam int CPU_PRESCALE_SEL_W = 3;
	localparam int PRE_W = 7;
	// Power modes, Gray along run-wait-active halt-halt
	typedef enum logic [1:0] {
		CLPMC_RUN = 2'b00,
		CLPMC_WAIT = 2'b01,
		CLPMC_AHALT = 2'b11,
		CLPMC_HALT = 2'b10
	} clpmc_mode_e;
	// Supply and oscillator controls
	typedef struct packed {
		logic main_reg_on;
		logic low_power_reg_on;
		logic hsi_on;
		logic hse_on;
		logic lsi_on;
	} clpmc_pwr_s;
	// Wake sources from the surrounding logic
	typedef struct packed {
		logic int_irq;
		logic comm_irq;
		logic awu_wake;
	} clpmc_wake_s;
endpackage

// >>> src/clpmc_top.sv
// Clock controller registers and low-power mode sequencer
module clpmc_top (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_wfi_i,
	input wire logic cpu_halt_i,
	input wire logic cpu_instr_done_i,
	input wire clpmc_pkg::clpmc_wake_s wake_i,
	input wire logic ext_irq_pin_i,
	input wire logic beeper_act_i,
	input wire logic independent_watchdog_act_i,
	input wire logic awu_use_hse_i,
	output logic cpu_clk_en_o,
	output logic mclk_en_o,
	output logic [15:0] periph_clk_en_o,
	output clpmc_pkg::clpmc_pwr_s pwr_o,
	output clpmc_pkg::clpmc_mode_e mode_o,
	output logic cpu_wake_o
);
	import clpmc_pkg::*;

	// Word index hit test
	function automatic logic hit(input logic [4:0] idx, input logic [4:0] r);
		hit = (idx == r);
	endfunction

	// Masked byte update
	function automatic logic [7:0] upd(input logic [7:0] old,
		input logic [7:0] wd, input logic [7:0] m);
		upd = (old & ~m) | (wd & m);
	endfunction

	// Register storage
	logic [7:0] int_osc_q, ext_osc_q, src_stat_q, src_sw_q, sw_ctrl_q;
	logic [7:0] clk_div_q, gate_one_q, clk_sec_q, clk_out_q, gate_two_q;
	logic [7:0] bus_div_q, rc_trim_q, dbg_clk_q;
	// Bus handshake state
	logic ack_q;
	logic [31:0] rdat_q;
	logic [4:0] idx;
	logic req;
	logic wr_fire;
	logic [7:0] wd;
	// Mode machine state
	clpmc_mode_e mode_q;
	logic wfi_pend_q, halt_pend_q;
	logic wake_q;
	// Pin synchroniser
	logic pin_s1_q, pin_s2_q;
	// CPU prescaler
	logic [PRE_W-1:0] pre_cnt_q;
	logic [PRE_W-1:0] pre_mask;
	logic cpu_tick;
	// Power outputs held in flops
	clpmc_pwr_s pwr_q;
	logic run_or_wait;
	logic ext_wake, wake_now;
	logic [7:0] rd_byte;

	assign idx = wb_adr_i[6:2];
	assign req = wb_cyc_i & wb_stb_i;
	// Write lands at the edge where the master sees ack
	assign wr_fire = req & wb_we_i & ack_q & wb_sel_i[0];
	assign wd = wb_dat_i[7:0];
	assign wb_ack_o = ack_q & req;
	assign wb_dat_o = rdat_q;

	// One-wait-state acknowledge, drops the cycle after
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	// Read mux; unmapped words read zero
	always_comb
	begin
		rd_byte = 8'h00;
		if (hit(idx, IDX_INT_OSC))
			rd_byte = int_osc_q;
		else if (hit(idx, IDX_EXT_OSC))
			rd_byte = ext_osc_q;
		else if (hit(idx, IDX_SRC_STAT))
			rd_byte = src_stat_q;
		else if (hit(idx, IDX_SRC_SW))
			rd_byte = src_sw_q;
		else if (hit(idx, IDX_SW_CTRL))
			rd_byte = sw_ctrl_q;
		else if (hit(idx, IDX_CLK_DIV))
			rd_byte = clk_div_q;
		else if (hit(idx, IDX_GATE_ONE))
			rd_byte = gate_one_q;
		else if (hit(idx, IDX_CLK_SEC))
			rd_byte = clk_sec_q;
		else if (hit(idx, IDX_CLK_OUT))
			rd_byte = clk_out_q;
		else if (hit(idx, IDX_GATE_TWO))
			rd_byte = gate_two_q;
		else if (hit(idx, IDX_BUS_DIV))
			rd_byte = bus_div_q;
		else if (hit(idx, IDX_RC_TRIM))
			rd_byte = rc_trim_q;
		else if (hit(idx, IDX_DBG_CLK))
			rd_byte = dbg_clk_q;
		else if (hit(idx, IDX_MODE_STAT))
			rd_byte = {4'h0, halt_pend_q, wfi_pend_q, mode_q};
	end

	// Read data captured on the request edge, stable through ack
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rdat_q <= 32'h0000_0000;
		else if (req & ~ack_q)
			rdat_q <= {24'h00_0000, rd_byte};
	end

	// Oscillator control with hardware ready flags
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_osc_q <= RST_INT_OSC;
			ext_osc_q <= RST_ZERO;
		end
		else
		begin
			if (wr_fire && hit(idx, IDX_INT_OSC))
				int_osc_q <= upd(int_osc_q, wd, WM_INT_OSC);
			if (wr_fire && hit(idx, IDX_EXT_OSC))
				ext_osc_q <= upd(ext_osc_q, wd, WM_EXT_OSC);
			// Ready flags mirror the oscillator enables one cycle late
			int_osc_q[B_LSIRDY] <= pwr_q.lsi_on;
			int_osc_q[B_HSIRDY] <= pwr_q.hsi_on;
			ext_osc_q[B_HSERDY] <= pwr_q.hse_on;
		end
	end

	// Source switch and status; fast wakeup forces the RC
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			src_sw_q <= RST_SRC;
			src_stat_q <= RST_SRC;
			sw_ctrl_q <= RST_ZERO;
		end
		else
		begin
			if (wr_fire && hit(idx, IDX_SRC_SW))
				src_sw_q <= wd;
			if (wr_fire && hit(idx, IDX_SW_CTRL))
				sw_ctrl_q <= upd(sw_ctrl_q, wd, WM_SW_CTRL);
			if (wake_now && (mode_q == CLPMC_HALT || mode_q == CLPMC_AHALT)
				&& int_osc_q[B_FHWU])
				src_stat_q <= SRC_HSI;
			else if (sw_ctrl_q[B_SWEN] && run_or_wait)
				src_stat_q <= src_sw_q;
		end
	end

	// Divider and gating registers, written only by software
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_div_q <= RST_CLK_DIV;
			gate_one_q <= RST_GATE;
			gate_two_q <= RST_GATE;
		end
		else if (wr_fire)
		begin
			if (hit(idx, IDX_GATE_ONE))
				gate_one_q <= wd;
			if (hit(idx, IDX_GATE_TWO))
				gate_two_q <= wd;
			if (hit(idx, IDX_CLK_DIV))
				clk_div_q <= upd(clk_div_q, wd, WM_CLK_DIV);
		end
	end

	// Remaining plain registers; security enable is write-once
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			clk_sec_q <= RST_ZERO;
			clk_out_q <= RST_ZERO;
			bus_div_q <= RST_ZERO;
			rc_trim_q <= RST_ZERO;
			dbg_clk_q <= RST_ZERO;
		end
		else if (wr_fire)
		begin
			if (hit(idx, IDX_CLK_SEC))
				clk_sec_q <= upd(clk_sec_q, wd, WM_CLK_SEC) |
					{7'h00, clk_sec_q[B_CSSEN]};
			if (hit(idx, IDX_CLK_OUT))
				clk_out_q <= upd(clk_out_q, wd, WM_CLK_OUT);
			if (hit(idx, IDX_BUS_DIV))
				bus_div_q <= upd(bus_div_q, wd, WM_BUS_DIV);
			if (hit(idx, IDX_RC_TRIM))
				rc_trim_q <= upd(rc_trim_q, wd, WM_RC_TRIM);
			if (hit(idx, IDX_DBG_CLK))
				dbg_clk_q <= upd(dbg_clk_q, wd, WM_DBG_CLK);
		end
	end

	// Two-flop synchroniser for the external interrupt pin
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end
		else
		begin
			pin_s1_q <= ext_irq_pin_i;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign ext_wake = pin_s2_q | wake_i.comm_irq;

	// Wake condition for the present mode
	always_comb
	begin
		unique case (mode_q)
			CLPMC_WAIT: wake_now = ext_wake | wake_i.int_irq | wake_i.awu_wake;
			CLPMC_AHALT: wake_now = ext_wake | wake_i.awu_wake;
			CLPMC_HALT: wake_now = ext_wake;
			CLPMC_RUN: wake_now = 1'b0;
		endcase
	end

	// Instruction requests held until the instruction retires
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wfi_pend_q <= 1'b0;
			halt_pend_q <= 1'b0;
		end
		else if (mode_q != CLPMC_RUN || cpu_instr_done_i)
		begin
			wfi_pend_q <= 1'b0;
			halt_pend_q <= 1'b0;
		end
		else
		begin
			wfi_pend_q <= wfi_pend_q | cpu_wfi_i;
			halt_pend_q <= halt_pend_q | cpu_halt_i;
		end
	end

	// Power mode machine
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mode_q <= CLPMC_RUN;
			wake_q <= 1'b0;
		end
		else
		begin
			wake_q <= wake_now;
			unique case (mode_q)
				CLPMC_RUN:
				begin
					if (cpu_instr_done_i && halt_pend_q)
						mode_q <= gate_two_q[B_AWU_GATE] ? CLPMC_AHALT
							: CLPMC_HALT;
					else if (cpu_instr_done_i && wfi_pend_q)
						mode_q <= CLPMC_WAIT;
				end
				CLPMC_WAIT, CLPMC_AHALT, CLPMC_HALT:
				begin
					if (wake_now)
						mode_q <= CLPMC_RUN;
				end
			endcase
		end
	end

	assign run_or_wait = (mode_q == CLPMC_RUN) || (mode_q == CLPMC_WAIT);

	// mask of two to the power of the code, minus one
	assign pre_mask = PRE_W'((8'h01 << clk_div_q[CPU_PRESCALE_SEL_W-1:0]) - 8'h01);

	// CPU prescaler counter; restarts whenever the divider is written
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pre_cnt_q <= '0;
		// a divider write restarts the count at once
		else if (wr_fire && hit(idx, IDX_CLK_DIV))
			pre_cnt_q <= '0;
		else if ((pre_cnt_q & pre_mask) == pre_mask)
			pre_cnt_q <= '0;
		else
			pre_cnt_q <= pre_cnt_q + PRE_W'(1);
	end

	// divider feeds the CPU enable only
	assign cpu_tick = ((pre_cnt_q & pre_mask) == pre_mask);
	assign cpu_clk_en_o = cpu_tick && (mode_q == CLPMC_RUN);
	// wait keeps master clock with any divider and gating
	assign mclk_en_o = run_or_wait;
	// gating applies in run and wait
	// gated peripherals keep their clock in wait
	always_comb
	begin
		periph_clk_en_o = 16'h0000;
		if (run_or_wait)
			periph_clk_en_o = {gate_two_q, gate_one_q};
		// only the auto-wakeup unit runs in active halt
		else if (mode_q == CLPMC_AHALT)
			periph_clk_en_o[8 + B_AWU_GATE] = 1'b1;
	end

	// Supply and oscillator controls, registered
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pwr_q <= '{main_reg_on: 1'b1, low_power_reg_on: 1'b1,
				hsi_on: 1'b1, hse_on: 1'b0, lsi_on: 1'b0};
		else
		begin
			pwr_q.low_power_reg_on <= 1'b1;
			// regulator off in active halt when asked
			pwr_q.main_reg_on <= run_or_wait ||
				(mode_q == CLPMC_AHALT && !int_osc_q[B_REGULATOR_OFF_IN_ACTIVE_HALT]);
			pwr_q.hsi_on <= run_or_wait && int_osc_q[B_HSIEN];
			// regulator-off active halt allows only the slow RC
			pwr_q.hse_on <= (run_or_wait && ext_osc_q[B_HSEEN]) ||
				(mode_q == CLPMC_AHALT && awu_use_hse_i &&
				!int_osc_q[B_REGULATOR_OFF_IN_ACTIVE_HALT]);
			// beeper or watchdog forces the slow RC
			pwr_q.lsi_on <= beeper_act_i || independent_watchdog_act_i ||
				(run_or_wait && int_osc_q[B_LSIEN]) ||
				(mode_q == CLPMC_AHALT &&
				(!awu_use_hse_i || int_osc_q[B_REGULATOR_OFF_IN_ACTIVE_HALT]));
		end
	end

	assign pwr_o = pwr_q;
	assign mode_o = mode_q;
	assign cpu_wake_o = wake_q;

	// no software-written field above is cleared by a mode change; the ready flags and pending requests follow the mode

	// Checks
	property p_run_after_reset;
		@(posedge clk) $rose(rst_b) |-> mode_q == CLPMC_RUN;
	endproperty
	a_run_after_reset: assert property (p_run_after_reset)
		else $error("not in run after reset");

	property p_cpu_stopped;
		@(posedge clk) disable iff (!rst_b)
		mode_q != CLPMC_RUN |-> !cpu_clk_en_o;
	endproperty
	a_cpu_stopped: assert property (p_cpu_stopped)
		else $error("cpu clock runs while not in run");

	property p_full_rate;
		@(posedge clk) disable iff (!rst_b)
		(clk_div_q[2:0] == 3'h0 && mode_q == CLPMC_RUN) |-> cpu_clk_en_o;
	endproperty
	a_full_rate: assert property (p_full_rate)
		else $error("undivided cpu clock missed a cycle");

	property p_div_two;
		@(posedge clk) disable iff (!rst_b)
		(clk_div_q[2:0] == 3'h1 && mode_q == CLPMC_RUN && cpu_clk_en_o)
		##1 (clk_div_q[2:0] == 3'h1 && mode_q == CLPMC_RUN) |-> !cpu_clk_en_o;
	endproperty
	a_div_two: assert property (p_div_two)
		else $error("divide by two ticked twice in a row");

	property p_periph_unaffected;
		@(posedge clk) disable iff (!rst_b)
		run_or_wait |-> periph_clk_en_o == {gate_two_q, gate_one_q}
			&& mclk_en_o;
	endproperty
	a_periph_unaffected: assert property (p_periph_unaffected)
		else $error("peripheral gating wrong in run or wait");

	property p_halt_wake_ext;
		@(posedge clk) disable iff (!rst_b)
		(mode_q == CLPMC_HALT && !ext_wake) |=> mode_q == CLPMC_HALT;
	endproperty
	a_halt_wake_ext: assert property (p_halt_wake_ext)
		else $error("halt left without external interrupt");

	property p_wait_wake;
		@(posedge clk) disable iff (!rst_b)
		(mode_q == CLPMC_WAIT && wake_i.int_irq) |=> mode_q == CLPMC_RUN;
	endproperty
	a_wait_wake: assert property (p_wait_wake)
		else $error("internal interrupt did not end wait");

	property p_no_early_entry;
		@(posedge clk) disable iff (!rst_b)
		(mode_q == CLPMC_RUN && !cpu_instr_done_i) |=> mode_q == CLPMC_RUN;
	endproperty
	a_no_early_entry: assert property (p_no_early_entry)
		else $error("low-power entry before instruction retired");

	property p_reg_off;
		@(posedge clk) disable iff (!rst_b)
		(mode_q == CLPMC_AHALT && int_osc_q[B_REGULATOR_OFF_IN_ACTIVE_HALT]) [*2]
			|-> !pwr_q.main_reg_on && !pwr_q.hse_on;
	endproperty
	a_reg_off: assert property (p_reg_off)
		else $error("main regulator or external osc on in active halt");

	property p_slow_rc_forced;
		@(posedge clk) disable iff (!rst_b)
		(beeper_act_i || independent_watchdog_act_i) |=> pwr_q.lsi_on;
	endproperty
	a_slow_rc_forced: assert property (p_slow_rc_forced)
		else $error("slow RC not forced on");

	c_wait_cycle: cover property (@(posedge clk) disable iff (!rst_b)
		mode_q == CLPMC_WAIT ##[1:50] mode_q == CLPMC_RUN);
	c_ahalt_cycle: cover property (@(posedge clk) disable iff (!rst_b)
		mode_q == CLPMC_AHALT ##[1:50] mode_q == CLPMC_RUN);
	c_halt_cycle: cover property (@(posedge clk) disable iff (!rst_b)
		mode_q == CLPMC_HALT ##[1:50] mode_q == CLPMC_RUN);
endmodule

// >>> tb/clpmc_cpu_model.sv
// CPU core stand-in that issues wait and halt instructions
module clpmc_cpu_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic go,
	input wire logic halt_sel,
	input wire logic [3:0] lag,
	output logic wfi_o,
	output logic halt_o,
	output logic done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Cycles left until the instruction retires
	logic [3:0] left_q;
	// request level, later retire
	// Request stays up through the retire cycle so entry sees both
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wfi_o <= 1'b0;
			halt_o <= 1'b0;
			done_o <= 1'b0;
			left_q <= 4'h0;
		end
		else if (go)
		begin
			// New instruction; a lag of zero would never retire
			wfi_o <= !halt_sel;
			halt_o <= halt_sel;
			done_o <= 1'b0;
			left_q <= (lag == 4'h0) ? 4'h1 : lag;
		end
		else if (left_q != 4'h0)
		begin
			// Counting down, retire pulse on the last count
			left_q <= left_q - 4'h1;
			done_o <= (left_q == 4'h1);
		end
		else
		begin
			// Instruction gone, CPU idles
			wfi_o <= 1'b0;
			halt_o <= 1'b0;
			done_o <= 1'b0;
		end
	end
endmodule

// >>> tb/clpmc_top_tb_top.sv
// Self-checking bench of the clock and low-power mode controller
module clpmc_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import clpmc_pkg::*;
	// Bus, CPU and wake stimulus
	logic clk, rst_b, cyc, stb, we, ack, go, halt_sel;
	logic [7:0] adr;
	logic [3:0] sel, lag;
	logic [31:0] wdat, rdat;
	logic wait_for_irq_instr, hlt, done, pin, beeper, independent_watchdog, use_hse;
	clpmc_wake_s wake;
	// Observed outputs
	logic cpu_en, mclk_en, cpu_wake;
	logic [15:0] pclk;
	clpmc_pwr_s pwr;
	clpmc_mode_e mode;
	int errors, cmp_count, k, s;
	// Reset table, unmapped and mode status words read zero
	logic [4:0] rix [14] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
		5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h02, 5'h10};
	logic [7:0] rval [14] = '{8'h00, 8'hE1, 8'hE1, 8'h00, 8'h18, 8'hFF,
		8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	// Access table: index, written value, value read back
	logic [4:0] aix [8] = '{5'h0B, 5'h0C, 5'h0D, 5'h03, 5'h02, 5'h08,
		5'h08, 5'h01};
	logic [7:0] aw [8] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h01,
		8'h00, 8'hFE};
	logic [7:0] ar [8] = '{8'h07, 8'h07, 8'h01, 8'hE1, 8'h00, 8'h01,
		8'h01, 8'h00};

	clpmc_top uut (
		.clk(clk),
		.rst_b(rst_b),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(wdat),
		.wb_dat_o(rdat),
		.wb_ack_o(ack),
		.cpu_wfi_i(wait_for_irq_instr),
		.cpu_halt_i(hlt),
		.cpu_instr_done_i(done),
		.wake_i(wake),
		.ext_irq_pin_i(pin),
		.beeper_act_i(beeper),
		.independent_watchdog_act_i(independent_watchdog),
		.awu_use_hse_i(use_hse),
		.cpu_clk_en_o(cpu_en),
		.mclk_en_o(mclk_en),
		.periph_clk_en_o(pclk),
		.pwr_o(pwr),
		.mode_o(mode),
		.cpu_wake_o(cpu_wake)
	);

	clpmc_cpu_model cpu (
		.clk(clk),
		.rst_b(rst_b),
		.go(go),
		.halt_sel(halt_sel),
		.lag(lag),
		.wfi_o(wait_for_irq_instr),
		.halt_o(hlt),
		.done_o(done)
	);

	// Free-running 125 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Verdict, the single end of the run
	task automatic stop_test();
		if (errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Compare one value, four-state exact
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask

	// Classic Wishbone cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [4:0] i,
		input logic [7:0] d, output logic [31:0] r);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= {1'b0, i, 2'b00};
		wdat <= {24'h0, d};
		n = 0;
		// Wait for ack however long it takes; the watchdog ends a hang
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ack !== 1'b1);
		// One wait state: ack stands at the second edge
		chk("ack_wait", 32'h2, n);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// Register write
	task automatic wr(input logic [4:0] i, input logic [7:0] d);
		logic [31:0] r;
		wb(1'b1, i, d, r);
	endtask

	// Register read against an expected byte
	task automatic rd(input string nm, input logic [4:0] i,
		input logic [7:0] e);
		logic [31:0] r;
		wb(1'b0, i, 8'h00, r);
		chk(nm, {24'h0, e}, r);
	endtask

	// Cycles between two CPU clock ticks
	task automatic period(input int k);
		int n;
		int t;
		n = 0;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (cpu_en !== 1'b1 && n < 300);
		t = 0;
		do
		begin
			@(negedge clk);
			t++;
		end
		while (cpu_en !== 1'b1 && t < 300);
		chk("cpu_period", 1 << k, t);
	endtask

	// Issue an instruction and check entry only at retirement
	task automatic enter(input logic h, input logic [3:0] l,
		input logic [1:0] e);
		int n;
		@(posedge clk);
		go <= 1'b1;
		halt_sel <= h;
		lag <= l;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		chk("mode_pre", CLPMC_RUN, mode);
		@(negedge clk);
		chk("mode", e, mode);
		chk("cpu_en", 32'h0, cpu_en);
		// Supply flops follow the mode one cycle later
		@(negedge clk);
	endtask

	// Drive one wake source for eight cycles, then release
	task automatic kick(input int s, input logic wk, input logic [1:0] m);
		int n;
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		case (s)
			0: wake.int_irq <= 1'b1;
			1: wake.comm_irq <= 1'b1;
			2: wake.awu_wake <= 1'b1;
			default: pin <= 1'b1;
		endcase
		for (n = 0; n < 8; n++)
		begin
			@(negedge clk);
			seen = seen | (cpu_wake === 1'b1);
		end
		chk("woke", wk, seen);
		chk("mode_after", wk ? CLPMC_RUN : m, mode);
		@(posedge clk);
		wake <= '0;
		pin <= 1'b0;
		@(posedge clk);
	endtask

	// Hang guard, well beyond the planned run
	initial
	begin
		#240000;
		errors++;
		stop_test();
	end

	// Main sequence
	initial
	begin
		{rst_b, cyc, stb, we, go, halt_sel, pin, beeper, independent_watchdog, use_hse} = '0;
		adr = 8'h00;
		sel = 4'h1;
		lag = 4'h1;
		wdat = 32'h0;
		wake = '0;
		errors = 0;
		cmp_count = 0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("mode", CLPMC_RUN, mode);
		chk("pwr", 32'h1C, pwr);
		chk("pclk", 32'hFFFF, pclk);
		// Fast RC enabled out of reset, so its ready flag is up
		rd("int_osc", IDX_INT_OSC, 8'h03);
		for (k = 0; k < 14; k++)
			rd("reset_val", rix[k], rval[k]);
		for (k = 0; k < 8; k++)
		begin
			wr(aix[k], aw[k]);
			rd("access", aix[k], ar[k]);
		end
		for (k = 0; k < 8; k++)
		begin
			wr(IDX_CLK_DIV, 8'h18 | k[7:0]);
			period(k);
			chk("mclk_en", 32'h1, mclk_en);
			chk("pclk_div", 32'hFFFF, pclk);
		end
		wr(IDX_CLK_DIV, 8'h18);
		@(negedge clk);
		chk("cpu_full", 32'h1, cpu_en);
		wr(IDX_GATE_ONE, 8'hA5);
		wr(IDX_GATE_TWO, 8'h38);
		wr(IDX_CLK_DIV, 8'h1B);
		chk("pclk_gate", 32'h38A5, pclk);
		for (s = 0; s < 4; s++)
		begin
			enter(1'b0, (s == 0) ? 4'h5 : 4'h1, CLPMC_WAIT);
			chk("pclk_wait", 32'h38A5, pclk);
			chk("mclk_wait", 32'h1, mclk_en);
			chk("reg_wait", 32'h1, pwr.main_reg_on & pwr.hsi_on);
			kick(s, 1'b1, CLPMC_WAIT);
			rd("div_kept", IDX_CLK_DIV, 8'h1B);
		end
		enter(1'b1, 4'h1, CLPMC_HALT);
		chk("mclk_halt", 32'h0, mclk_en);
		chk("pclk_halt", 32'h0, pclk);
		chk("pwr_halt", 32'h08, pwr);
		kick(2, 1'b0, CLPMC_HALT);
		kick(0, 1'b0, CLPMC_HALT);
		kick(1, 1'b1, CLPMC_HALT);
		for (k = 0; k < 2; k++)
		begin
			beeper <= (k == 0);
			independent_watchdog <= (k == 1);
			enter(1'b1, 4'h2, CLPMC_HALT);
			chk("lsi_forced", 32'h1, pwr.lsi_on);
			kick(3, 1'b1, CLPMC_HALT);
		end
		beeper <= 1'b0;
		independent_watchdog <= 1'b0;
		wr(IDX_GATE_TWO, 8'h3C);
		enter(1'b1, 4'h1, CLPMC_AHALT);
		chk("pclk_ah", 32'h0400, pclk);
		chk("pwr_ah", 32'h11, pwr & 5'h13);
		kick(0, 1'b0, CLPMC_AHALT);
		kick(2, 1'b1, CLPMC_AHALT);
		use_hse <= 1'b1;
		enter(1'b1, 4'h1, CLPMC_AHALT);
		chk("hse_ah", 32'h1, pwr.hse_on);
		kick(3, 1'b1, CLPMC_AHALT);
		wr(IDX_INT_OSC, 8'h21);
		enter(1'b1, 4'h1, CLPMC_AHALT);
		chk("pwr_regoff", 32'h09, pwr & 5'h1B);
		kick(2, 1'b1, CLPMC_AHALT);
		chk("main_back", 32'h1, pwr.main_reg_on);
		use_hse <= 1'b0;
		wr(IDX_SRC_SW, 8'hB4);
		wr(IDX_SW_CTRL, 8'h02);
		rd("src_follow", IDX_SRC_STAT, 8'hB4);
		wr(IDX_SW_CTRL, 8'h00);
		wr(IDX_INT_OSC, 8'h05);
		enter(1'b1, 4'h1, CLPMC_AHALT);
		kick(2, 1'b1, CLPMC_AHALT);
		rd("src_fast", IDX_SRC_STAT, SRC_HSI);
		enter(1'b0, 4'h1, CLPMC_WAIT);
		@(posedge clk);
		rst_b <= 1'b0;
		@(posedge clk);
		rst_b <= 1'b1;
		@(negedge clk);
		chk("mode_rst", CLPMC_RUN, mode);
		rd("div_rst", IDX_CLK_DIV, 8'h18);
		stop_test();
	end
endmodule
